// ===== shared/comp_cond_defines.vh
// Function
// [RULE_01] The trigger sense field picks level, falling, rising or either-edge ADC events.
// [RULE_02] In level mode the interrupt is active while the output equals the irq level bit.
// [RULE_03] The irq sense field picks level, falling, rising or either-edge interrupts.
// [RULE_04] The invert bit inverts the comparator output before any detection uses it.
// [RULE_05] Bit 0 of the control register reads zero and ignores writes.
// [RULE_06] In level mode the ADC event is active while the output equals the trigger level bit.
// [RULE_07] The ADC event reaches the ADC only while the trigger output enable bit is set.
// [RULE_08] The output is synchronised and edges are one-cycle pulses from consecutive samples.
`ifndef COMP_COND_DEFINES_VH
`define COMP_COND_DEFINES_VH
// ==========================================
// register offsets
`define OFS_CONTROL        12'h024
`define OFS_IRQ_STATUS     12'h028
`define OFS_IRQ_MASK       12'h02C
`define OFS_LIVE_STATE     12'h030
// ==========================================
// control fields
`define BIT_INVERT         1
`define BIT_IRQ_LVL_LO     2
`define BIT_IRQ_LVL_HI     3
`define BIT_IRQ_LEVEL      4
`define BIT_TRG_SEL_LO     5
`define BIT_TRG_SEL_HI     6
`define BIT_TRG_LEVEL      7
`define BIT_TRG_OUT_EN     11
`define CONTROL_WMASK      32'h000008FE
`define CONTROL_RESET      32'h00000000
// ==========================================
// sense encodings
`define SENSE_LEVEL        2'h0
`define SENSE_FALL         2'h1
`define SENSE_RISE         2'h2
`define SENSE_BOTH         2'h3
// ==========================================
// status bits
`define STAT_IRQ           0
`define STAT_TRG           1
`define STAT_WIDTH         2
`endif

// ===== hdl/sense_detect.v
`timescale 1ns/1ns
`include "comp_cond_defines.vh"
module sense_detect (
	// samples
	input  wire       i_cur,
	input  wire       i_prev,
	// config
	input  wire [1:0] i_sel,
	input  wire       i_level,
	// result
	output reg        o_hit
);
	always @* begin
		case (i_sel)
			`SENSE_LEVEL: o_hit = (i_cur == i_level);       // see [RULE_02] see [RULE_06]
			`SENSE_FALL:  o_hit = i_prev & ~i_cur;          // see [RULE_08]
			`SENSE_RISE:  o_hit = ~i_prev & i_cur;
			default:      o_hit = i_prev ^ i_cur;           // see [RULE_01] see [RULE_03]
		endcase
	end
endmodule // sense_detect

// ===== hdl/comp_cond.v
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "comp_cond_defines.vh"
module comp_cond (
	// clock and reset
	input  wire        i_ref_clk,
	input  wire        i_rstn,
	// apb
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata_ff,
	output reg         o_pready_ff,
	output reg         o_pslverr_ff,
	// comparator and adc
	input  wire        i_comp_out,
	output reg         o_adc_trigger_ff,
	output reg         o_irq_ff
);
	reg  [31:0] control_ff;
	reg  [1:0]  stat_ff;
	reg  [1:0]  mask_ff;
	reg         sync1_ff;
	reg         sync2_ff;
	reg         cur_ff;
	reg         prev_ff;
	wire        irq_hit;
	wire        trg_hit;
	wire        setup;
	wire        wr;
	wire        mapped;
	reg  [1:0]  nxt_stat;
	reg  [31:0] nxt_rdata;
	// control fields
	wire        output_invert;
	wire [1:0]  irq_sense_select;
	wire        irq_level_value;
	wire [1:0]  trigger_sense_select;
	wire        trigger_level_value;
	wire        trigger_out_enable;
	// address decode and strobes
	wire        sel_control;
	wire        sel_status;
	wire        sel_mask;
	wire        sel_live;
	wire        wr_control;
	wire        wr_status;
	wire        wr_mask;
	wire        rd_setup;
	// next values
	reg  [31:0] nxt_control;
	reg  [1:0]  nxt_mask;
	reg         nxt_trigger;
	reg         nxt_irq;

	// ==========================================
	// sync and condition
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= i_comp_out;                                       // see [RULE_08]
			sync2_ff <= sync1_ff;
		end
	end

	// inversion ahead of both detectors
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cur_ff  <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			cur_ff  <= sync2_ff ^ output_invert;                          // see [RULE_04]
			prev_ff <= cur_ff;
		end
	end

	// ==========================================
	// control fields
	assign output_invert        = control_ff[`BIT_INVERT];
	assign irq_sense_select     = control_ff[`BIT_IRQ_LVL_HI:`BIT_IRQ_LVL_LO];
	assign irq_level_value      = control_ff[`BIT_IRQ_LEVEL];
	assign trigger_sense_select = control_ff[`BIT_TRG_SEL_HI:`BIT_TRG_SEL_LO];
	assign trigger_level_value  = control_ff[`BIT_TRG_LEVEL];
	assign trigger_out_enable   = control_ff[`BIT_TRG_OUT_EN];

	// ==========================================
	// detectors
	// both see the same conditioned samples
	sense_detect u_irq_det (
		.i_cur   (cur_ff),
		.i_prev  (prev_ff),
		.i_sel   (irq_sense_select),
		.i_level (irq_level_value),
		.o_hit   (irq_hit)
	);
	sense_detect u_trg_det (
		.i_cur   (cur_ff),
		.i_prev  (prev_ff),
		.i_sel   (trigger_sense_select),
		.i_level (trigger_level_value),
		.o_hit   (trg_hit)
	);

	// ==========================================
	// apb decode
	assign setup       = i_psel & ~i_penable;
	assign rd_setup    = setup & ~i_pwrite;
	assign wr          = i_psel & i_penable & o_pready_ff & i_pwrite;
	assign sel_control = (i_paddr == `OFS_CONTROL);
	assign sel_status  = (i_paddr == `OFS_IRQ_STATUS);
	assign sel_mask    = (i_paddr == `OFS_IRQ_MASK);
	assign sel_live    = (i_paddr == `OFS_LIVE_STATE);
	assign mapped      = sel_control | sel_status | sel_mask | sel_live;
	// unmapped writes fall through untouched
	assign wr_control  = wr & sel_control;
	assign wr_status   = wr & sel_status;
	assign wr_mask     = wr & sel_mask;

	// ==========================================
	// next values
	always @* begin
		nxt_control = control_ff;
		if (wr_control) begin
			nxt_control = i_pwdata & `CONTROL_WMASK;                    // see [RULE_05]
		end
	end

	always @* begin
		nxt_mask = mask_ff;
		if (wr_mask) begin
			nxt_mask = i_pwdata[1:0];
		end
	end

	always @* begin
		nxt_stat = stat_ff;
		if (wr_status) begin
			nxt_stat = stat_ff & ~i_pwdata[1:0];
		end
		// set wins over clear
		nxt_stat[`STAT_IRQ] = nxt_stat[`STAT_IRQ] | irq_hit;
		nxt_stat[`STAT_TRG] = nxt_stat[`STAT_TRG] | trg_hit;
	end

	// trigger gated here, status still records the hit
	always @* begin
		nxt_trigger = trg_hit & trigger_out_enable;                      // see [RULE_07]
		nxt_irq     = |(nxt_stat & mask_ff);
	end

	always @* begin
		nxt_rdata = 32'h00000000;
		case (i_paddr)
			`OFS_CONTROL:    nxt_rdata = control_ff;                      // see [RULE_05]
			`OFS_IRQ_STATUS: nxt_rdata = {30'h00000000, stat_ff};
			`OFS_IRQ_MASK:   nxt_rdata = {30'h00000000, mask_ff};
			`OFS_LIVE_STATE: nxt_rdata = {30'h00000000, trg_hit, cur_ff};
			default:         nxt_rdata = 32'h00000000;
		endcase
	end

	// ==========================================
	// apb response, one wait-free access cycle
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_prdata_ff  <= 32'h00000000;
			o_pready_ff  <= 1'b0;
			o_pslverr_ff <= 1'b0;
		end else begin
			o_pready_ff  <= setup;
			o_pslverr_ff <= setup & ~mapped;
			if (rd_setup) begin
				o_prdata_ff <= nxt_rdata;
			end
		end
	end

	// ==========================================
	// configuration registers
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			control_ff <= `CONTROL_RESET;
			mask_ff    <= 2'h0;
		end else begin
			control_ff <= nxt_control;
			mask_ff    <= nxt_mask;
		end
	end

	// ==========================================
	// sticky status
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stat_ff <= 2'h0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// ==========================================
	// outputs
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_adc_trigger_ff <= 1'b0;
			o_irq_ff         <= 1'b0;
		end else begin
			o_adc_trigger_ff <= nxt_trigger;
			o_irq_ff         <= nxt_irq;
		end
	end
endmodule // comp_cond

// ===== tb/comp_model.sv
`timescale 1ns/1ns
module comp_model (
	input  wire logic i_ref_clk,
	input  wire logic want,
	input  wire logic o_adc_trigger_ff,
	output logic      i_comp_out,
	output int        pulses
);
	initial i_comp_out = 0;
	initial pulses = 0;
	always @(posedge i_ref_clk) begin
		i_comp_out <= want;
		pulses     <= pulses + o_adc_trigger_ff;
	end
endmodule // comp_model

// ===== tb/comp_cond_chk.sv
`timescale 1ns/1ns
`include "comp_cond_defines.vh"
module comp_cond_chk (input wire i_ref_clk, i_rstn, i_psel, i_penable, i_pwrite,
	input wire [11:0] i_paddr, input wire [31:0] i_pwdata, o_prdata_ff,
	input wire o_pready_ff, o_pslverr_ff, i_comp_out, o_adc_trigger_ff, o_irq_ff);
	logic [31:0] ctl_ff;
	wire acc = i_psel && i_penable && o_pready_ff;
	wire map = i_paddr inside {`OFS_CONTROL, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_LIVE_STATE};
	wire lvl = ctl_ff[6:5] == 2'h0 && ctl_ff[11] && (i_comp_out ^ ctl_ff[1]) == ctl_ff[7];
	always @(posedge i_ref_clk or negedge i_rstn)
		if (!i_rstn) ctl_ff <= 32'h0;
		else if (acc && i_pwrite && i_paddr == `OFS_CONTROL) ctl_ff <= i_pwdata & `CONTROL_WMASK;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	property p_rdy; i_psel && !i_penable |=> o_pready_ff; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; o_pready_ff |=> !o_pready_ff; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_err; acc |-> o_pslverr_ff == !map; endproperty
	a_err: assert property (p_err) else $error("bad slverr");
	property p_rd; acc && !i_pwrite && i_paddr == `OFS_CONTROL |-> o_prdata_ff == ctl_ff; endproperty
	a_rd: assert property (p_rd) else $error("bad control");
	property p_en; o_adc_trigger_ff |-> $past(ctl_ff[11]); endproperty
	a_en: assert property (p_en) else $error("ungated trigger");
	property p_pls; ctl_ff[6:5] != 2'h0 && $stable(ctl_ff) && o_adc_trigger_ff |=> !o_adc_trigger_ff; endproperty
	a_pls: assert property (p_pls) else $error("long pulse");
	property p_lvl; lvl [*6] |-> o_adc_trigger_ff; endproperty
	a_lvl: assert property (p_lvl) else $error("no level");
	property p_nlvl; (ctl_ff[6:5] == 2'h0 && !lvl) [*6] |-> !o_adc_trigger_ff; endproperty
	a_nlvl: assert property (p_nlvl) else $error("false level");
	c_err: cover property (acc && o_pslverr_ff);
	c_trg: cover property (o_adc_trigger_ff);
	c_irq: cover property (o_irq_ff);
endmodule // comp_cond_chk
bind comp_cond comp_cond_chk comp_cond_chk_i (.*);

// ===== tb/testbench.sv
`timescale 1ns/1ns
`include "comp_cond_defines.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        i_ref_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, want = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata_ff, rd;
	logic        o_pready_ff, o_pslverr_ff, i_comp_out, o_adc_trigger_ff, o_irq_ff, er;
	int          bad_count = 0, checks_done = 0, cyc = 0, pulses, c;
	comp_cond comp_cond_i (.*);
	comp_model comp_model_i (.*);
	initial forever #4 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			close_out;
		end
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
		@(posedge i_ref_clk) i_penable <= 1;
		do @(posedge i_ref_clk); while (o_pready_ff !== 1'b1);
		rd = o_prdata_ff; er = o_pslverr_ff;
		i_psel <= 0; i_penable <= 0;
		@(posedge i_ref_clk);
	endtask
	// rising comparator edge, trigger pulses counted
	task rise(output int n);
		want <= 0; repeat (10) @(posedge i_ref_clk); n = pulses;
		want <= 1; repeat (10) @(posedge i_ref_clk); n = pulses - n;
	endtask
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1;
		apb(0, `OFS_CONTROL, 0); `CHK("ctl reset", 32'h0, rd)
		apb(1, `OFS_CONTROL, 32'hFFFFFFFF); apb(0, `OFS_CONTROL, 0);
		`CHK("ctl bits", `CONTROL_WMASK, rd)
		apb(0, 12'h100, 0); `CHK("unmapped", 33'h100000000, {er, rd})
		$display("regs done");
		for (int i = 0; i < 6; i++) begin
			apb(1, `OFS_CONTROL, 32'h800 | (i % 3 + 1) << 5 | (i / 3) << 1); rise(c);
			`CHK("edges", i % 3 == 2 || i % 3 + i / 3 == 1, c)
		end
		apb(1, `OFS_CONTROL, 32'h060); rise(c); `CHK("gated", 0, c)
		apb(1, `OFS_CONTROL, 32'h880); repeat (10) @(posedge i_ref_clk);
		`CHK("lvl hi", 1'b1, o_adc_trigger_ff)
		want <= 0; repeat (10) @(posedge i_ref_clk);
		`CHK("lvl lo", 1'b0, o_adc_trigger_ff)
		$display("trigger done");
		apb(1, `OFS_IRQ_MASK, 1); apb(1, `OFS_CONTROL, 32'h008); apb(1, `OFS_IRQ_STATUS, 3);
		`CHK("irq idle", 1'b0, o_irq_ff)
		rise(c); `CHK("irq rise", 1'b1, o_irq_ff)
		apb(0, `OFS_IRQ_STATUS, 0); `CHK("status", 1'b1, rd[0])
		apb(1, `OFS_IRQ_STATUS, 1); `CHK("irq clr", 1'b0, o_irq_ff)
		apb(1, `OFS_CONTROL, 32'h010); apb(1, `OFS_IRQ_STATUS, 1);
		`CHK("irq lvl", 1'b1, o_irq_ff)
		apb(1, `OFS_IRQ_MASK, 0); apb(1, `OFS_CONTROL, 0); repeat (10) @(posedge i_ref_clk);
		`CHK("masked", 1'b0, o_irq_ff)
		apb(1, `OFS_IRQ_MASK, 1); apb(1, `OFS_IRQ_STATUS, 1);
		`CHK("lvl low idle", 1'b0, o_irq_ff)
		want <= 0; repeat (10) @(posedge i_ref_clk);
		`CHK("lvl low", 1'b1, o_irq_ff)
		$display("irq done");
		close_out;
	end
endmodule // testbench
